//--- logic/ccg_map.svh
// Constants of the check-code generator: polynomial mask, reset values, bit positions
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH

// Feedback taps at bits 15, 13 and 0 after the right shift
`define CCG_CRC_MASK  16'ha001
`define CCG_CRC_INIT  16'h0000
`define CCG_LRC_INIT  8'h00
`define CCG_BYTE_ZERO 8'h00
`define CCG_KEEP_ZERO 7'h00
`define CCG_CNT_ZERO  3'h0
`define CCG_CNT_ONE   3'h1
`define CCG_LAST_BIT  3'h7
`define CCG_BYTE_BITS 8
`define CCG_PAR_INIT  1'b1

`endif

//--- logic/ccg_parity.sv
// Bit-serial odd parity and longitudinal block parity engine
`include "ccg_map.svh"

module ccg_parity (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Step controls and results
	ccg_step_if.eng  e
);
	import ccg_pkg::*;

	ccg_byte_t   sh_reg;
	ccg_byte_t   sh_next;
	logic [6:0]  keep_reg;
	logic [6:0]  keep_next;
	logic        par_reg;
	logic        par_next;
	ccg_byte_t   char_reg;
	ccg_byte_t   char_next;
	ccg_byte_t   lrc_reg;
	ccg_byte_t   lrc_next;

	// Next values; the last step only assembles, bit 7 is not counted
	always_comb begin
		sh_next   = sh_reg;
		keep_next = keep_reg;
		par_next  = par_reg;
		char_next = char_reg;
		lrc_next  = lrc_reg;
		if (e.clr) begin
			lrc_next = `CCG_LRC_INIT;
		end
		if (e.start) begin
			sh_next   = e.data;
			keep_next = e.data[6:0];
			par_next  = `CCG_PAR_INIT;
		end else if (e.step) begin
			if (e.idx != `CCG_LAST_BIT && sh_reg[0]) begin
				par_next = ~par_reg;
			end
			sh_next = {1'b0, sh_reg[7:1]};
			if (e.idx == `CCG_LAST_BIT) begin
				char_next = {par_reg, keep_reg};
				lrc_next  = lrc_reg ^ {par_reg, keep_reg};
			end
		end
	end

	// Registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sh_reg   <= `CCG_BYTE_ZERO;
			keep_reg <= `CCG_KEEP_ZERO;
			par_reg  <= `CCG_PAR_INIT;
			char_reg <= `CCG_BYTE_ZERO;
			lrc_reg  <= `CCG_LRC_INIT;
		end else begin
			sh_reg   <= sh_next;
			keep_reg <= keep_next;
			par_reg  <= par_next;
			char_reg <= char_next;
			lrc_reg  <= lrc_next;
		end
	end

	assign e.char_out = char_reg;
	assign e.lrc      = lrc_reg;

	// Finished character always carries an odd count of ones
	property p_parity_odd;
		@(posedge clk) disable iff (!rst_n)
		(e.step && e.idx == `CCG_LAST_BIT) |=> (^char_reg) == 1'b1;
	endproperty
	a_parity_odd: assert property (p_parity_odd) else $error("character parity not odd");

	// Block parity folds in exactly the new character
	property p_lrc_accum;
		@(posedge clk) disable iff (!rst_n)
		(e.step && e.idx == `CCG_LAST_BIT && !e.clr) |=> lrc_reg == ($past(lrc_reg) ^ char_reg);
	endproperty
	a_lrc_accum: assert property (p_lrc_accum) else $error("lrc not accumulated");

endmodule : ccg_parity

//--- logic/ccg_pkg.sv
// Types shared by the check-code generator modules
package ccg_pkg;

	typedef logic [7:0]  ccg_byte_t;
	typedef logic [15:0] ccg_crc_t;
	typedef logic [2:0]  ccg_cnt_t;

	// One-hot sequencer states
	typedef enum logic [1:0] {
		CCG_IDLE  = 2'b01,
		CCG_SHIFT = 2'b10
	} ccg_state_t;

endpackage : ccg_pkg

//--- logic/ccg_step_if.sv
// Carrier between the bit sequencer and the parity and longitudinal engine
interface ccg_step_if;
	import ccg_pkg::*;

	logic      clr;
	logic      start;
	logic      step;
	ccg_cnt_t  idx;
	ccg_byte_t data;
	ccg_byte_t char_out;
	ccg_byte_t lrc;

	modport ctl (output clr, output start, output step, output idx, output data,
	             input char_out, input lrc);
	modport eng (input clr, input start, input step, input idx, input data,
	             output char_out, output lrc);

endinterface : ccg_step_if

//--- logic/ccg_top.sv
// Check-code generator: CRC-16, odd character parity and block longitudinal parity
// How it works
// - Each accepted byte is folded into the 16-bit code, one update per data bit.
// - Generator polynomial is x16 + x15 + x2 + 1.
// - Each step shifts right; feedback from code LSB versus data bit hits bits 15, 13, 0.
// - Data byte enters least significant bit first; eight steps finish it.
// - Odd parity over the seven data bits lands in bit 7 of the character.
// - Every finished character is XORed into the block parity byte.
// - Parity toggles once per set bit among data bits 0 to 6; bit 7 is not counted.
`include "ccg_map.svh"

module ccg_top (
	// Clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RST_N,
	// Byte stream in
	input  wire logic              CLR_STRING,
	input  wire logic              BYTE_VALID,
	input  wire ccg_pkg::ccg_byte_t BYTE_DATA,
	// Status
	output logic                   BUSY,
	output logic                   DONE,
	// Check codes
	output ccg_pkg::ccg_crc_t      CRC_OUT,
	output ccg_pkg::ccg_byte_t     CHAR_OUT,
	output ccg_pkg::ccg_byte_t     LRC_OUT
);
	import ccg_pkg::*;

	ccg_state_t state_reg;
	ccg_state_t state_next;
	ccg_crc_t   crc_reg;
	ccg_crc_t   crc_next;
	ccg_byte_t  shift_reg;
	ccg_byte_t  shift_next;
	ccg_cnt_t   cnt_reg;
	ccg_cnt_t   cnt_next;
	logic       busy_reg;
	logic       busy_next;
	logic       done_reg;
	logic       done_next;
	logic       accept;
	ccg_crc_t   exp_reg;

	ccg_step_if st ();

	// One feedback shift step of the code register
	function automatic ccg_crc_t crc_bit(input ccg_crc_t c, input logic d);
		logic fb;
		fb = c[0] ^ d;
		crc_bit = {1'b0, c[15:1]} ^ (fb ? `CCG_CRC_MASK : `CCG_CRC_INIT);
	endfunction : crc_bit

	// Whole byte, used as the reference for the serial result
	function automatic ccg_crc_t crc_byte(input ccg_crc_t c, input ccg_byte_t d);
		ccg_crc_t r;
		r = c;
		for (int i = 0; i < `CCG_BYTE_BITS; i++) begin
			r = crc_bit(r, d[i]);
		end
		crc_byte = r;
	endfunction : crc_byte

	// Byte taken only in idle; a strobe while busy is ignored
	assign accept = (state_reg == CCG_IDLE) && BYTE_VALID;

	// Sequencer next values; one bit per clock keeps the logic tiny at the cost of latency
	always_comb begin
		state_next = state_reg;
		crc_next   = crc_reg;
		shift_next = shift_reg;
		cnt_next   = cnt_reg;
		busy_next  = busy_reg;
		done_next  = 1'b0;
		case (state_reg)
			CCG_IDLE: begin
				if (CLR_STRING) begin
					crc_next = `CCG_CRC_INIT;
				end
				if (BYTE_VALID) begin
					shift_next = BYTE_DATA;
					cnt_next   = `CCG_CNT_ZERO;
					busy_next  = 1'b1;
					state_next = CCG_SHIFT;
				end
			end
			CCG_SHIFT: begin
				crc_next   = crc_bit(crc_reg, shift_reg[0]);
				shift_next = {1'b0, shift_reg[7:1]};
				if (cnt_reg == `CCG_LAST_BIT) begin
					state_next = CCG_IDLE;
					busy_next  = 1'b0;
					done_next  = 1'b1;
				end else begin
					cnt_next = cnt_reg + `CCG_CNT_ONE;
				end
			end
			default: begin
				state_next = CCG_IDLE;
				busy_next  = 1'b0;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_reg <= CCG_IDLE;
			crc_reg   <= `CCG_CRC_INIT;
			shift_reg <= `CCG_BYTE_ZERO;
			cnt_reg   <= `CCG_CNT_ZERO;
			busy_reg  <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			crc_reg   <= crc_next;
			shift_reg <= shift_next;
			cnt_reg   <= cnt_next;
			busy_reg  <= busy_next;
			done_reg  <= done_next;
		end
	end

	// Controls toward the parity engine; clear is honoured only between bytes
	assign st.clr   = (state_reg == CCG_IDLE) && CLR_STRING;
	assign st.start = accept;
	assign st.step  = (state_reg == CCG_SHIFT);
	assign st.idx   = cnt_reg;
	assign st.data  = BYTE_DATA;

	ccg_parity u_parity (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.e     (st.eng)
	);

	// Outputs, all from flip-flops
	assign BUSY     = busy_reg;
	assign DONE     = done_reg;
	assign CRC_OUT  = crc_reg;
	assign CHAR_OUT = st.char_out;
	assign LRC_OUT  = st.lrc;

	// Reference code captured at accept, checked only by assertions
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			exp_reg <= `CCG_CRC_INIT;
		end else if (accept) begin
			exp_reg <= crc_byte(CLR_STRING ? `CCG_CRC_INIT : crc_reg, BYTE_DATA);
		end
	end

	sequence s_accept;
		(state_reg == CCG_IDLE) && BYTE_VALID;
	endsequence

	sequence s_eight_quiet_then_done;
		(!done_reg)[*8] ##1 done_reg;
	endsequence

	// Serial result matches the whole-byte reference
	property p_crc_byte;
		@(posedge CLK_SYS) disable iff (!RST_N)
		done_reg |-> crc_reg == exp_reg;
	endproperty
	a_crc_byte: assert property (p_crc_byte) else $error("crc byte result wrong");

	// Done arrives exactly eight steps after the byte is taken
	property p_done_timing;
		@(posedge CLK_SYS) disable iff (!RST_N)
		s_accept |=> s_eight_quiet_then_done;
	endproperty
	a_done_timing: assert property (p_done_timing) else $error("done not after eight");

	// Busy covers the eight steps and drops with done
	property p_busy_span;
		@(posedge CLK_SYS) disable iff (!RST_N)
		s_accept |=> BUSY[*8] ##1 (!BUSY && DONE);
	endproperty
	a_busy_span: assert property (p_busy_span) else $error("busy span wrong");

	// Done is a single-cycle pulse
	property p_done_pulse;
		@(posedge CLK_SYS) disable iff (!RST_N)
		done_reg |=> !done_reg;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

	// Data moves toward the LSB by one place per step
	property p_lsb_first;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(state_reg == CCG_SHIFT) |=> shift_reg == ($past(shift_reg) >> 1);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("data not shifted lsb first");

	// String clear zeroes both check codes
	property p_clear;
		@(posedge CLK_SYS) disable iff (!RST_N)
		((state_reg == CCG_IDLE) && CLR_STRING) |=> (crc_reg == `CCG_CRC_INIT)
			&& (LRC_OUT == `CCG_LRC_INIT);
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not zero codes");

endmodule : ccg_top

//--- sim/ccg_src.sv
// Byte source model feeding the check-code generator
module ccg_src (
	// Clock and status
	input  wire logic          CLK_SYS,
	input  wire logic          BUSY,
	// Strobes and data
	output logic               CLR_STRING,
	output logic               BYTE_VALID,
	output ccg_pkg::ccg_byte_t BYTE_DATA
);
	timeunit 1ns;
	timeprecision 1ps;
	import ccg_pkg::*;

	// Quiet until the first request
	initial begin
		CLR_STRING = 1'b0;
		BYTE_VALID = 1'b0;
		BYTE_DATA  = 8'h00;
	end

	// One-cycle strobe; anyway skips the idle wait, used for the back-to-back and refusal tests
	task automatic send(input ccg_byte_t d, input logic clr, input logic anyway,
		input int gap, input int tail);
		repeat (gap) @(posedge CLK_SYS);
		if (!anyway) begin
			@(negedge CLK_SYS);
			while (BUSY !== 1'b0) @(negedge CLK_SYS);
			@(posedge CLK_SYS);
		end
		CLR_STRING <= clr;
		BYTE_VALID <= 1'b1;
		BYTE_DATA  <= d;
		@(posedge CLK_SYS);
		CLR_STRING <= 1'b0;
		BYTE_VALID <= 1'b0;
		BYTE_DATA  <= ~d; // Released bus never shows a stale byte
		repeat (tail) @(posedge CLK_SYS);
	endtask : send

	// Clear pulse with no byte, issued only between bytes
	task automatic clear_only(input int tail);
		@(negedge CLK_SYS);
		while (BUSY !== 1'b0) @(negedge CLK_SYS);
		@(posedge CLK_SYS);
		CLR_STRING <= 1'b1;
		@(posedge CLK_SYS);
		CLR_STRING <= 1'b0;
		repeat (tail) @(posedge CLK_SYS);
	endtask : clear_only
endmodule : ccg_src

//--- sim/test_crc16_parity_lrc_gen.sv
// Self-checking bench of the check-code generator against a reference model
module test_crc16_parity_lrc_gen;
	timeunit 1ns;
	timeprecision 1ps;
	import ccg_pkg::*;

	logic      CLK_SYS = 1'b0;
	logic      RST_N   = 1'b0;
	logic      CLR_STRING;
	logic      BYTE_VALID;
	logic      BUSY;
	logic      DONE;
	ccg_byte_t BYTE_DATA;
	ccg_byte_t CHAR_OUT;
	ccg_byte_t LRC_OUT;
	ccg_crc_t  CRC_OUT;
	ccg_byte_t codes[6] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h01, 8'h5a};
	int        error_cnt = 0;
	int        cmp_count = 0;
	int        seed      = 32'hbe7b6e69;
	int        cyc       = 0;
	int        t0;
	int        mcrc;
	int        mlrc;
	int        mleft;
	logic      mdone;
	logic      mclr;
	int        q[$];

	// 200 MHz clock
	always #2.5 CLK_SYS = ~CLK_SYS;

	ccg_top ccg_top_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CLR_STRING(CLR_STRING),
		.BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA), .BUSY(BUSY), .DONE(DONE),
		.CRC_OUT(CRC_OUT), .CHAR_OUT(CHAR_OUT), .LRC_OUT(LRC_OUT));
	ccg_src ccg_src_i (.CLK_SYS(CLK_SYS), .BUSY(BUSY), .CLR_STRING(CLR_STRING),
		.BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA));

	// Shared counting and reporting
	task automatic check(input logic ok, input logic [15:0] got, input int exp);
		cmp_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp[15:0]);
		end
	endtask : check
	task automatic cmp_crc(input ccg_crc_t g, input int e);
		check(g === 16'(e), g, e);
	endtask : cmp_crc
	task automatic cmp_chr(input ccg_byte_t g, input int e);
		check(g === 8'(e), {8'h00, g}, e);
	endtask : cmp_chr
	task automatic cmp_lrc(input ccg_byte_t g, input int e);
		check(g === 8'(e), {8'h00, g}, e);
	endtask : cmp_lrc
	task automatic cmp_lat(input int g, input int e);
		check(g == e, 16'(g), e);
	endtask : cmp_lat
	task automatic cmp_flag(input logic g, input logic e);
		check(g === e, 16'(g), int'(e));
	endtask : cmp_flag

	// Reference fold of one byte, LSB first, reflected taps
	function automatic int crc_f(input int c, input int d);
		for (int i = 0; i < 8; i++) begin
			c = ((c ^ (d >> i)) & 1) ? ((c >> 1) ^ 32'h0000a001) : (c >> 1);
		end
		return c;
	endfunction : crc_f

	// Reference character: toggle per set bit of bits 0 to 6, odd parity into bit 7
	function automatic int chr_f(input int d);
		int p;
		p = 1;
		for (int i = 0; i < 7; i++) begin
			if ((d >> i) & 1) p ^= 1;
		end
		return (d & 32'h7f) | (p << 7);
	endfunction : chr_f

	// Model sees pre-edge values: checks status and finished bytes, then takes requests
	always @(posedge CLK_SYS) begin
		cyc++;
		if (RST_N !== 1'b1) begin
			mcrc  = 0;
			mlrc  = 0;
			mleft = 0;
			mdone = 1'b0;
			mclr  = 1'b0;
		end else begin
			cmp_flag(BUSY, mleft != 0);
			cmp_flag(DONE, mdone);
			if (mclr) begin
				cmp_crc(CRC_OUT, 0);
				cmp_lrc(LRC_OUT, 0);
			end
			if (DONE === 1'b1) begin
				cmp_lat(cyc - t0, 9);
				cmp_crc(CRC_OUT, q.pop_front());
				cmp_chr(CHAR_OUT, q.pop_front());
				cmp_lrc(LRC_OUT, q.pop_front());
			end
			mdone = (mleft == 1);
			if (mleft > 0) mleft--;
			mclr = (mleft == 0) && (CLR_STRING === 1'b1);
			if (mclr) begin
				mcrc = 0;
				mlrc = 0;
			end
		end
		if (RST_N === 1'b1 && mleft == 0 && BYTE_VALID === 1'b1) begin
			mleft = 8;
			t0 = cyc;
			mcrc = crc_f(mcrc, BYTE_DATA);
			mlrc ^= chr_f(BYTE_DATA);
			q.push_back(mcrc);
			q.push_back(chr_f(BYTE_DATA));
			q.push_back(mlrc);
		end
	end

	// Reset, directed codes, back to back, refused strobe, random stream
	initial begin
		ccg_byte_t d;
		repeat (16) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		@(posedge CLK_SYS);
		cmp_crc(CRC_OUT, 0);
		cmp_chr(CHAR_OUT, 0);
		cmp_lrc(LRC_OUT, 0);
		$display("test reset done");
		foreach (codes[i]) ccg_src_i.send(codes[i], i == 0, 1'b0, 0, 0);
		ccg_src_i.clear_only(0);
		ccg_src_i.send(8'ha5, 1'b0, 1'b0, 0, 0);
		$display("test directed done");
		ccg_src_i.send(8'h3c, 1'b1, 1'b0, 0, 8);
		ccg_src_i.send(8'hc3, 1'b0, 1'b1, 0, 0);
		$display("test back to back done");
		ccg_src_i.send(8'h96, 1'b0, 1'b0, 0, 2);
		ccg_src_i.send(8'h69, 1'b1, 1'b1, 0, 0);
		$display("test refused strobe done");
		repeat (200) begin
			d = 8'($random(seed));
			if (($random(seed) & 31) == 0) ccg_src_i.clear_only(0);
			ccg_src_i.send(d, ($random(seed) & 15) == 0, 1'b0, $random(seed) & 3, 0);
		end
		repeat (12) @(posedge CLK_SYS);
		cmp_lat(q.size(), 0);
		$display("test random done");
		end_of_test();
	end

	// Watchdog sized well past the expected run
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		error_cnt++;
		end_of_test();
	end

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
endmodule : test_crc16_parity_lrc_gen
